// ==== rtl/comparator_pkg.sv ====
/*
  Constants and carrier types shared by the dual comparator control block:
  special-function-register addresses, bit positions inside the registers,
  reset values and the packed structs for the register port and the analog
  front end controls.
  Assumes an 8-bit special function register port driven by the CPU core.
*/
package comparator_pkg;

  // ---------------------------------------------------------------------
  // Register addresses on the special function register port
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h9B; // Comparator 0 control.
  localparam logic [7:0] ADDR_CTRL1 = 8'h9A; // Comparator 1 control.
  localparam logic [7:0] ADDR_MUX0  = 8'h9F; // Comparator 0 input select.
  localparam logic [7:0] ADDR_MUX1  = 8'h9E; // Comparator 1 input select.
  localparam logic [7:0] ADDR_MODE0 = 8'h9D; // Comparator 0 response mode.
  localparam logic [7:0] ADDR_MODE1 = 8'h9C; // Comparator 1 response mode.

  // ---------------------------------------------------------------------
  // Bit positions inside the control register
  // ---------------------------------------------------------------------
  localparam int BIT_EN   = 7; // Comparator enable bit.
  localparam int BIT_OUT  = 6; // Read-only output state bit.
  localparam int BIT_RISE = 5; // Sticky rising edge flag.
  localparam int BIT_FALL = 4; // Sticky falling edge flag.
  localparam int HYP_LO   = 2; // Positive hysteresis field, low bit.
  localparam int HYN_LO   = 0; // Negative hysteresis field, low bit.

  // ---------------------------------------------------------------------
  // Field layout of the select and mode registers
  // ---------------------------------------------------------------------
  localparam int FIELD_W  = 2; // Every select, mode and hysteresis field.
  localparam int MUX_NEG  = 4; // Negative input select, low bit.
  localparam int MUX_POS  = 0; // Positive input select, low bit.
  localparam int MODE_LO  = 0; // Response mode field, low bit.

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [1:0] FIELD_RESET = 2'h0; // Select and hysteresis fields reset to zero.
  localparam logic [1:0] MODE_RESET  = 2'h2; // Response mode after reset.
  localparam logic [7:0] READ_IDLE   = 8'h00; // Unmapped or idle read.

  // Register port request from the CPU core.
  typedef struct packed {
    logic [7:0] addr;  // Register address.
    logic [7:0] wdata; // Write data.
    logic       we;    // Write strobe, one cycle.
    logic       rd;    // Read strobe, one cycle.
  } sfr_req_t;

  // Settings forwarded to one analog comparator.
  typedef struct packed {
    logic       enable;        // Comparator powered and active.
    logic [1:0] pos_hyst;      // Positive hysteresis code, 0 is off.
    logic [1:0] neg_hyst;      // Negative hysteresis code, 0 is off.
    logic [1:0] pos_sel;       // Positive input select.
    logic [1:0] neg_sel;       // Negative input select.
    logic [1:0] response_mode; // Speed versus supply current.
  } analog_ctrl_t;

endpackage : comparator_pkg

// ==== rtl/dual_voltage_comparator_ctrl.sv ====
/*
  Control and status logic for two voltage comparators: enable, input
  selection, response mode and hysteresis registers, the latched and raw
  outputs, sticky edge flags and the reset source of comparator 0.
  Assumes the analog comparators deliver their results on cmp_result and
  that the CPU core presents one register request per cycle.
*/
`timescale 1ns/1ps

module dual_voltage_comparator_ctrl (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire comparator_pkg::sfr_req_t    sfr_req,
  output logic [7:0]                       sfr_rdata,
  output logic                             sfr_hit,
  input  wire logic [1:0]                  cmp_result,
  output comparator_pkg::analog_ctrl_t     analog_ctrl [2],
  output logic                             cmp0_latched_out,
  output logic                             cmp1_latched_out,
  output logic                             cmp0_raw_out,
  output logic                             cmp1_raw_out,
  output logic                             cmp0_reset_source,
  output logic [1:0]                       edge_irq
);
  import comparator_pkg::*;

  // ---------------------------------------------------------------------
  // Address tables and decode
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR [2] = '{ADDR_CTRL0, ADDR_CTRL1};
  localparam logic [7:0] MUX_ADDR  [2] = '{ADDR_MUX0, ADDR_MUX1};
  localparam logic [7:0] MODE_ADDR [2] = '{ADDR_MODE0, ADDR_MODE1};

  // Decode of one address against one register; shared by writes and reads.
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = (addr == target);
  endfunction : reg_hit

  logic [7:0] ctrl_view [2]; // Control register as software reads it.
  logic [7:0] mux_view  [2]; // Input select register as read.
  logic [7:0] mode_view [2]; // Response mode register as read.
  logic [1:0] latched;       // Clock-synchronised comparator outputs.
  logic [1:0] raw;           // Unclocked comparator outputs.

  // ---------------------------------------------------------------------
  // Per-comparator registers and output logic
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      logic       en, next_en;            // Enable bit.
      logic [1:0] hyp, next_hyp;          // Positive hysteresis code.
      logic [1:0] hyn, next_hyn;          // Negative hysteresis code.
      logic       rise, next_rise;        // Sticky rising edge flag.
      logic       fall, next_fall;        // Sticky falling edge flag.
      logic [1:0] psel, next_psel;        // Positive input select.
      logic [1:0] nsel, next_nsel;        // Negative input select.
      logic [1:0] mode, next_mode;        // Response mode.
      logic       samp, next_samp;        // Latched output sample.
      logic       prev, next_prev;        // Previous latched sample.
      logic       wr_ctrl, wr_mux, wr_mode;

      // Write decode for this comparator's three registers.
      assign wr_ctrl = sfr_req.we && reg_hit(sfr_req.addr, CTRL_ADDR[gi]);
      assign wr_mux  = sfr_req.we && reg_hit(sfr_req.addr, MUX_ADDR[gi]);
      assign wr_mode = sfr_req.we && reg_hit(sfr_req.addr, MODE_ADDR[gi]);

      // Next-state logic. Bit 6 is never written: it only reflects state.
      always_comb begin
        next_en   = en;
        next_hyp  = hyp;
        next_hyn  = hyn;
        next_psel = psel;
        next_nsel = nsel;
        next_mode = mode;
        if (wr_ctrl) begin
          next_en  = sfr_req.wdata[BIT_EN];
          next_hyp = sfr_req.wdata[HYP_LO +: FIELD_W];
          next_hyn = sfr_req.wdata[HYN_LO +: FIELD_W];
        end
        if (wr_mux) begin
          next_psel = sfr_req.wdata[MUX_POS +: FIELD_W];
          next_nsel = sfr_req.wdata[MUX_NEG +: FIELD_W];
        end
        if (wr_mode) begin
          next_mode = sfr_req.wdata[MODE_LO +: FIELD_W];
        end
        // A disabled comparator samples low, so its pin rests low.
        next_samp = en & cmp_result[gi];
        next_prev = samp;
        // An edge in the very cycle of a clearing write still sets the
        // flag; writing one leaves the flag as it was.
        next_rise = (rise && !(wr_ctrl && !sfr_req.wdata[BIT_RISE]))
                    || (samp && !prev);
        next_fall = (fall && !(wr_ctrl && !sfr_req.wdata[BIT_FALL]))
                    || (!samp && prev);
      end

      // State registers, synchronous active-low reset.
      always_ff @(posedge clk) begin
        if (!rstn) begin
          en   <= 1'b0;
          hyp  <= FIELD_RESET;
          hyn  <= FIELD_RESET;
          rise <= 1'b0;
          fall <= 1'b0;
          psel <= FIELD_RESET;
          nsel <= FIELD_RESET;
          mode <= MODE_RESET;
          samp <= 1'b0;
          prev <= 1'b0;
        end else begin
          en   <= next_en;
          hyp  <= next_hyp;
          hyn  <= next_hyn;
          rise <= next_rise;
          fall <= next_fall;
          psel <= next_psel;
          nsel <= next_nsel;
          mode <= next_mode;
          samp <= next_samp;
          prev <= next_prev;
        end
      end

      // The raw path is pure gating so it keeps working with the clock
      // stopped; only the enable, held in a flop, is involved.
      assign raw[gi]     = en & cmp_result[gi];
      assign latched[gi] = samp;
      assign edge_irq[gi] = rise | fall;

      // Hysteresis codes pass unchanged; code zero means none.
      assign analog_ctrl[gi] = '{enable:        en,
                                 pos_hyst:      hyp,
                                 neg_hyst:      hyn,
                                 pos_sel:       psel,
                                 neg_sel:       nsel,
                                 response_mode: mode};

      // Register views for readback; unused bits read as zero.
      always_comb begin
        ctrl_view[gi]                      = READ_IDLE;
        ctrl_view[gi][BIT_EN]              = en;
        ctrl_view[gi][BIT_OUT]             = samp;
        ctrl_view[gi][BIT_RISE]            = rise;
        ctrl_view[gi][BIT_FALL]            = fall;
        ctrl_view[gi][HYP_LO +: FIELD_W]   = hyp;
        ctrl_view[gi][HYN_LO +: FIELD_W]   = hyn;
        mux_view[gi]                       = READ_IDLE;
        mux_view[gi][MUX_POS +: FIELD_W]   = psel;
        mux_view[gi][MUX_NEG +: FIELD_W]   = nsel;
        mode_view[gi]                      = READ_IDLE;
        mode_view[gi][MODE_LO +: FIELD_W]  = mode;
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Pin-level outputs
  // ---------------------------------------------------------------------
  assign cmp0_latched_out = latched[0];
  assign cmp1_latched_out = latched[1];
  assign cmp0_raw_out     = raw[0];
  assign cmp1_raw_out     = raw[1];
  // Comparator 0 only: a low result of an enabled comparator requests
  // reset. The reset controller decides whether this source is armed.
  assign cmp0_reset_source = analog_ctrl[0].enable & ~latched[0];

  // ---------------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------------
  logic [7:0] next_rdata; // Read data for the next cycle.
  logic       next_hit;   // Address matched one of the six registers.

  // Read mux; an unmapped address answers zero with sfr_hit low.
  always_comb begin
    next_rdata = READ_IDLE;
    next_hit   = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (sfr_req.rd && reg_hit(sfr_req.addr, CTRL_ADDR[i])) begin
        next_rdata = ctrl_view[i];
        next_hit   = 1'b1;
      end
      if (sfr_req.rd && reg_hit(sfr_req.addr, MUX_ADDR[i])) begin
        next_rdata = mux_view[i];
        next_hit   = 1'b1;
      end
      if (sfr_req.rd && reg_hit(sfr_req.addr, MODE_ADDR[i])) begin
        next_rdata = mode_view[i];
        next_hit   = 1'b1;
      end
    end
  end

  // Read data is registered so the core sees a clean value.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sfr_rdata <= READ_IDLE;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_rdata <= next_rdata;
      sfr_hit   <= next_hit;
    end
  end

endmodule : dual_voltage_comparator_ctrl

// ==== tb/comparator_assertions.sv ====
/* Port assertions for the comparator control block.
   Assumes a bind from tb_top to every top-level port by name. */
`timescale 1ns/1ps
module comparator_assertions (
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire comparator_pkg::sfr_req_t     sfr_req,
  input wire logic [7:0]                   sfr_rdata,
  input wire logic                         sfr_hit,
  input wire logic [1:0]                   cmp_result,
  input wire comparator_pkg::analog_ctrl_t analog_ctrl [2],
  input wire logic                         cmp0_latched_out,
  input wire logic                         cmp1_latched_out,
  input wire logic                         cmp0_raw_out,
  input wire logic                         cmp1_raw_out,
  input wire logic                         cmp0_reset_source,
  input wire logic [1:0]                   edge_irq
);
  import comparator_pkg::*;
  // ---------------------------------------------------------------
  // One clock domain, so clocking and reset are given once.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Write and read strobes decoded here to keep the properties short.
  wire w1 = sfr_req.we && sfr_req.addr == ADDR_CTRL1;
  wire wm = sfr_req.we && sfr_req.addr == ADDR_MUX0;
  wire wd = sfr_req.we && sfr_req.addr == ADDR_MODE1;
  wire r0 = sfr_req.rd && sfr_req.addr == ADDR_CTRL0;
  property p_raw;
    cmp1_raw_out == (analog_ctrl[1].enable && cmp_result[1]); endproperty
  a_raw: assert property (p_raw)
    else $error("raw output wrong");
  property p_latch; cmp0_latched_out == $past(cmp0_raw_out); endproperty
  a_latch: assert property (p_latch)
    else $error("latched output wrong");
  property p_rise; $rose(cmp0_latched_out) |=> edge_irq[0]; endproperty
  a_rise: assert property (p_rise)
    else $error("rise flag missing");
  property p_fall; $fell(cmp1_latched_out) |=> edge_irq[1]; endproperty
  a_fall: assert property (p_fall)
    else $error("fall flag missing");
  property p_hold; edge_irq[1] && !w1 |=> edge_irq[1]; endproperty
  a_hold: assert property (p_hold)
    else $error("flag lost");
  property p_rsrc;
    cmp0_reset_source == (analog_ctrl[0].enable && !cmp0_latched_out);
  endproperty
  a_rsrc: assert property (p_rsrc)
    else $error("reset source wrong");
  property p_ctrl; w1 |=> {analog_ctrl[1].enable, analog_ctrl[1].pos_hyst,
    analog_ctrl[1].neg_hyst} == $past({sfr_req.wdata[7], sfr_req.wdata[3:0]});
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control write lost");
  property p_mux; wm |=> {analog_ctrl[0].pos_sel, analog_ctrl[0].neg_sel}
    == $past({sfr_req.wdata[1:0], sfr_req.wdata[5:4]}); endproperty
  a_mux: assert property (p_mux)
    else $error("select write lost");
  property p_mode;
    wd |=> analog_ctrl[1].response_mode == $past(sfr_req.wdata[1:0]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode write lost");
  property p_read;
    r0 |=> sfr_hit && sfr_rdata[7] == $past(analog_ctrl[0].enable);
  endproperty
  a_read: assert property (p_read)
    else $error("control read wrong");
  c_rise: cover property ($rose(cmp0_latched_out) ##2 edge_irq[0]);
  c_fall: cover property ($fell(cmp1_latched_out) ##2 edge_irq[1]);
  c_read: cover property (r0 ##1 sfr_hit);
endmodule : comparator_assertions

// ==== tb/analog_front_model.sv ====
/* Behavioural pair of analog comparators facing the control block.
   Assumes the bench sets the wanted result of each on level. */
`timescale 1ns/1ps
module analog_front_model (
  input wire logic                         clk,
  input wire comparator_pkg::analog_ctrl_t analog_ctrl [2],
  input wire logic [1:0]                   level,
  output logic [1:0]                       cmp_result
);
  import comparator_pkg::*;
  logic junk; // Changes every cycle.
  // A powered-down comparator gives no valid result, so the model
  // shows a moving pattern rather than a settled level.
  always @(posedge clk) begin
    junk <= (junk === 1'b1) ? 1'b0 : 1'b1;
  end
  // Enabled comparators follow the wanted level at once.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_result[i] = analog_ctrl[i].enable ? level[i] : junk;
    end
  end
endmodule : analog_front_model

// ==== tb/tb_top.sv ====
/* Self-checking bench with a register image model of the block.
   Assumes the package, design, partner model and checker are built. */
`timescale 1ns/1ps
module tb_top;
  import comparator_pkg::*;
  logic         clk = 1'b0;   // 250 MHz system clock.
  logic         rstn = 1'b0;  // Synchronous reset, active low.
  sfr_req_t     sfr_req = '0; // Register request.
  logic [1:0]   level = 2'h0; // Wanted analog results.
  logic [7:0]   sfr_rdata;
  logic         sfr_hit, rsrc;
  logic [1:0]   cmp_result, lat, raw, edge_irq;
  analog_ctrl_t analog_ctrl [2];
  int           failures = 0;
  int           comparisons = 0;
  int           k;
  logic [7:0]   regs [6]; // Model of the six registers.
  logic [7:0]   addrs [6] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_MUX0,
                              ADDR_MUX1, ADDR_MODE0, ADDR_MODE1};
  logic [7:0]   masks [6] = '{8'h8F, 8'h8F, 8'h33, 8'h33, 8'h03, 8'h03};
  always #2 clk = ~clk;
  dual_voltage_comparator_ctrl uut (.clk(clk), .rstn(rstn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .cmp_result(cmp_result), .analog_ctrl(analog_ctrl),
    .cmp0_latched_out(lat[0]), .cmp1_latched_out(lat[1]),
    .cmp0_raw_out(raw[0]), .cmp1_raw_out(raw[1]),
    .cmp0_reset_source(rsrc), .edge_irq(edge_irq));
  analog_front_model fe (.clk(clk), .analog_ctrl(analog_ctrl),
    .level(level), .cmp_result(cmp_result));
  // Expected read value: output state joins the stored bits.
  function automatic logic [7:0] exp_rd(input int j);
    return regs[j] | ((j < 2 && regs[j][7] && level[j]) ? 8'h40 : 8'h00);
  endfunction : exp_rd
  function automatic logic [10:0] exp_ac(input int i);
    return {regs[i][7], regs[i][3:0], regs[2+i][1:0], regs[2+i][5:4],
            regs[4+i][1:0]};
  endfunction : exp_ac
  task automatic chk(input logic [10:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Write; flags only clear, and disabling a high output sets fall.
  task automatic wr(input int j, input logic [7:0] d);
    logic f;
    @(negedge clk);
    sfr_req.addr = addrs[j];
    sfr_req.wdata = d;
    sfr_req.we = 1'b1;
    @(negedge clk);
    sfr_req.we = 1'b0;
    f = j < 2 && regs[j][7] && level[j] && !d[7];
    regs[j] = (d & masks[j]) | (j < 2 ? regs[j] & d & 8'h30 : 8'h00);
    if (f) regs[j][4] = 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input logic h);
    @(negedge clk);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    @(negedge clk);
    sfr_req.rd = 1'b0;
    chk(11'({sfr_hit, sfr_rdata}), 11'({h, e}), "read");
  endtask : rd
  // Move one analog result; an enabled comparator records the edge.
  task automatic lvl(input int i, input logic v);
    level[i] = v;
    // The raw path must move before any clock edge; the latched copy
    // still shows the old level, since the level always toggles here.
    #1;
    chk(11'({raw[i], lat[i]}),
      11'({regs[i][7] & v, regs[i][7] & ~v}), "raw path");
    if (regs[i][7]) regs[i][v ? 5 : 4] = 1'b1;
    repeat (3) @(negedge clk);
    chk(11'({lat[i], raw[i], edge_irq[i], rsrc}),
      11'({regs[i][7] & v, regs[i][7] & v, |regs[i][5:4],
      regs[0][7] & ~level[0]}), "pins");
  endtask : lvl
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    void'($urandom(13));
    regs = '{8'h00, 8'h00, 8'h00, 8'h00, MODE_RESET, MODE_RESET};
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (int j = 0; j < 6; j++) rd(addrs[j], exp_rd(j), 1'b1);
    rd(8'h99, READ_IDLE, 1'b0);
    $display("reset test done");
    for (int n = 0; n < 24; n++) begin
      k = $urandom_range(5);
      wr(k, 8'($urandom));
      rd(addrs[k], exp_rd(k), 1'b1);
      chk(11'(analog_ctrl[k%2]), exp_ac(k % 2), "settings");
    end
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      wr(i, 8'h80);
      lvl(i, 1'b1);
      rd(addrs[i], exp_rd(i), 1'b1);
      lvl(i, 1'b0);
      rd(addrs[i], exp_rd(i), 1'b1);
      wr(i, 8'hA0);
      lvl(i, 1'b1);
      rd(addrs[i], exp_rd(i), 1'b1);
      wr(i, 8'h00);
      repeat (3) @(negedge clk);
      rd(addrs[i], exp_rd(i), 1'b1);
      lvl(i, 1'b0);
    end
    $display("edge test done");
    close_out();
  end
  initial begin
    #20000;
    failures++;
    $display("Error %0t: watchdog expired", $time);
    close_out();
  end
endmodule : tb_top
bind dual_voltage_comparator_ctrl comparator_assertions chk_i (.clk(clk),
  .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .cmp_result(cmp_result), .analog_ctrl(analog_ctrl),
  .cmp0_latched_out(cmp0_latched_out), .cmp1_latched_out(cmp1_latched_out),
  .cmp0_raw_out(cmp0_raw_out), .cmp1_raw_out(cmp1_raw_out),
  .cmp0_reset_source(cmp0_reset_source), .edge_irq(edge_irq));
